// ===== inc/apsc_pkg.sv
package apsc_pkg;

  // Register byte offsets on the AHB-Lite slave.
  localparam logic [7:0] CMD_OFS    = 8'h00;
  localparam logic [7:0] RESULT_OFS = 8'h04;
  localparam logic [7:0] MRADDR_OFS = 8'h08;
  localparam logic [7:0] MRDATA_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;

  // Command word layout: function code above a 16-bit operand.
  localparam int CMD_WIDTH    = 20;
  localparam int FUNC_LSB     = 16;
  localparam int OPERAND_BITS = 16;

  localparam logic [3:0] FUNC_INTERVAL = 4'h4;
  localparam logic [3:0] FUNC_COUNT    = 4'hB;
  localparam logic [3:0] FUNC_START    = 4'hC;
  localparam logic [3:0] FUNC_PROGRESS = 4'hD;

  // Result codes returned for each command.
  localparam logic [15:0] RES_OK          = 16'h0000;
  localparam logic [15:0] RES_BAD_OPERAND = 16'h0001;
  localparam logic [15:0] RES_BAD_FUNC    = 16'h0002;

  // Start operand selects the position source.
  localparam logic [15:0] SRC_FEEDBACK = 16'h0000;
  localparam logic [15:0] SRC_COMMAND  = 16'h0001;

  localparam int AXES        = 4;
  localparam int MAX_SAMPLES = 7500;
  localparam logic [15:0] MEM_BASE = 16'h4000;
  localparam logic [15:0] MEM_LAST = 16'hB52F;
  localparam int MEM_WORDS = AXES * MAX_SAMPLES;
  localparam int MEM_AW    = 15;

  localparam logic [15:0] INTERVAL_RESET = 16'h0001;
  localparam logic [15:0] COUNT_RESET    = 16'h1D4C;

  // Status register bit positions.
  localparam int STAT_BUSY   = 0;
  localparam int STAT_SOURCE = 1;
  localparam int STAT_MRBUSY = 2;

  // Sample time base.
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_NS       = 1000000;
  localparam int CYCLES_PER_MS = TICK_NS / CLK_PERIOD_NS;

  localparam int FIFO_DEPTH = 4;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_PUSH
  } apsc_state_t;

endpackage

// ===== rtl/apsc_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module apsc_fifo #(
  parameter int WIDTH = 47,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             flush,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("apsc_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW:0]      wrPtr_reg;
  logic [PW:0]      rdPtr_reg;
  logic             pushOk;
  logic             popOk;

  assign inReady  = (wrPtr_reg - rdPtr_reg) != (PW + 1)'(DEPTH);
  assign outValid = wrPtr_reg != rdPtr_reg;
  assign outData  = store[rdPtr_reg[PW-1:0]];
  assign pushOk   = inValid && inReady;
  assign popOk    = outValid && outReady;

  always_ff @(posedge clk) begin
    if (ce && pushOk && !flush) begin
      store[wrPtr_reg[PW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else if (ce) begin
      if (flush) begin
        wrPtr_reg <= '0;
        rdPtr_reg <= '0;
      end else begin
        if (pushOk) begin
          wrPtr_reg <= wrPtr_reg + 1'b1;
        end
        if (popOk) begin
          rdPtr_reg <= rdPtr_reg + 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/apsc_capture.sv
// Operation
// - Hold up to 7500 four-axis samples; counts outside 1 to 7500 are refused.
// - Sample interval is the programmed value times one millisecond.
// - Function 0x4 loads interval from operand; host supplies 1 to 65535.
// - Function 0xB loads sample count from operand; host keeps it 1 to 7500.
// - Function 0xC starts sampling; operand 0 feedback, 1 commanded positions.
// - Function 0xD returns remaining progress count, zero once capture completes.
// - Samples go to word addresses 4000 to B52F hex, lowest first.
// - Each sample writes axes 1 to 4 at consecutive addresses.
// - Sample memory stays readable by the host during and after capture.
// - Every command returns a result code to the issuer.
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module apsc_capture
#(
  parameter int TICK_CYCLES = apsc_pkg::CYCLES_PER_MS,
  parameter int DEPTH       = apsc_pkg::FIFO_DEPTH
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      ce,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic      [31:0]               hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  input  wire logic [apsc_pkg::AXES-1:0][31:0] fbPos,
  input  wire logic [apsc_pkg::AXES-1:0][31:0] cmdPos,
  output logic                           captureBusy
);
  import apsc_pkg::*;

  // Parameter values that the logic cannot serve stop elaboration.
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 1");
  end
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be a power of two, at least 2");
  end
  if (MEM_WORDS > (1 << MEM_AW)) begin : g_bad_aw
    $error("MEM_AW is too narrow for the sample memory");
  end
  if (int'(MEM_LAST) - int'(MEM_BASE) + 1 != MEM_WORDS) begin : g_bad_region
    $error("sample region size disagrees with MEM_WORDS");
  end

  localparam int ENTRY_W = MEM_AW + 32;
  localparam int TW      = $clog2(TICK_CYCLES + 1);

  function automatic logic inRegion(input logic [31:0] a);
    return (a >= {16'h0000, MEM_BASE}) && (a <= {16'h0000, MEM_LAST});
  endfunction

  // Registers live in the lowest 256 bytes; any higher address reads zero and ignores writes.
  function automatic logic lowPage(input logic [31:0] a);
    return a[31:8] == 24'h000000;
  endfunction

  // AHB-Lite address phase capture.
  logic        wrPend_reg;
  logic [7:0]  wrAddr_reg;
  logic        takeAddr;
  logic        wordAccess;

  // A write is only remembered here; it takes effect in the data phase, when hwdata is valid.
  assign wordAccess = hsize == 3'b010;
  assign takeAddr   = hsel && htrans[1] && hready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
    end else if (ce) begin
      wrPend_reg <= takeAddr && hwrite && wordAccess && lowPage(haddr);
      if (takeAddr) begin
        wrAddr_reg <= haddr[7:0];
      end
    end
  end

  // The slave never stretches a transfer, so ready rises once after reset and stays high.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Command decode from a write to the command register.
  logic        cmdWrite;
  logic [3:0]  cmdFunc;
  logic [15:0] cmdOperand;
  assign cmdWrite   = wrPend_reg && wrAddr_reg == CMD_OFS;
  assign cmdFunc    = hwdata[CMD_WIDTH-1:FUNC_LSB];
  assign cmdOperand = hwdata[OPERAND_BITS-1:0];

  logic [15:0] interval_reg;
  logic [15:0] count_reg;
  logic        source_reg;
  logic [15:0] result_reg;
  logic [15:0] remaining_reg;
  logic        startCmd;

  assign startCmd = cmdWrite && cmdFunc == FUNC_START &&
                    (cmdOperand == SRC_FEEDBACK || cmdOperand == SRC_COMMAND);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interval_reg <= INTERVAL_RESET;
      count_reg    <= COUNT_RESET;
      source_reg   <= 1'b0;
      result_reg   <= RES_OK;
    end else if (ce && cmdWrite) begin
      unique case (cmdFunc)
        FUNC_INTERVAL: begin
          if (cmdOperand != 16'h0000) begin
            interval_reg <= cmdOperand;
            result_reg   <= RES_OK;
          end else begin
            result_reg <= RES_BAD_OPERAND;
          end
        end
        FUNC_COUNT: begin
          if (cmdOperand != 16'h0000 && cmdOperand <= 16'(MAX_SAMPLES)) begin
            count_reg  <= cmdOperand;
            result_reg <= RES_OK;
          end else begin
            result_reg <= RES_BAD_OPERAND;
          end
        end
        FUNC_START: begin
          if (startCmd) begin
            source_reg <= cmdOperand[0];
            result_reg <= RES_OK;
          end else begin
            result_reg <= RES_BAD_OPERAND;
          end
        end
        FUNC_PROGRESS: begin
          // A progress query hands back the number of samples still to come.
          result_reg <= remaining_reg;
        end
        default: begin
          result_reg <= RES_BAD_FUNC;
        end
      endcase
    end
  end

  // Millisecond time base and interval counter.
  logic [TW-1:0] msCnt_reg;
  logic [15:0]   ivCnt_reg;
  logic          msTick;
  logic          sampleDue;
  apsc_state_t   state_reg;

  // Both counters restart whenever the sequencer leaves the wait state, so each interval is whole.
  assign msTick    = msCnt_reg == TW'(TICK_CYCLES - 1);
  assign sampleDue = state_reg == ST_WAIT && msTick && ivCnt_reg == interval_reg - 16'h0001;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      msCnt_reg <= '0;
      ivCnt_reg <= 16'h0000;
    end else if (ce) begin
      if (startCmd || state_reg != ST_WAIT) begin
        msCnt_reg <= '0;
        ivCnt_reg <= 16'h0000;
      end else if (msTick) begin
        msCnt_reg <= '0;
        ivCnt_reg <= sampleDue ? 16'h0000 : ivCnt_reg + 16'h0001;
      end else begin
        msCnt_reg <= msCnt_reg + 1'b1;
      end
    end
  end

  // Capture sequencer: snapshot four positions, push them one by one.
  logic [31:0]           snap_reg [AXES];
  logic [1:0]            axis_reg;
  logic [MEM_AW-1:0]     wrIdx_reg;
  logic                  pushValid;
  logic                  pushReady;
  logic                  pushed;
  logic                  lastWord;
  logic                  lastSample;
  logic                  snapCmd;

  assign pushValid  = state_reg == ST_PUSH;
  assign pushed     = pushValid && pushReady;
  // The fourth word closes a sample; the last word of the last sample ends the capture.
  assign lastWord   = pushed && axis_reg == 2'(AXES - 1);
  assign lastSample = lastWord && remaining_reg == 16'h0001;
  assign snapCmd    = startCmd ? cmdOperand[0] : source_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= ST_IDLE;
      axis_reg      <= 2'b00;
      wrIdx_reg     <= '0;
      remaining_reg <= 16'h0000;
    end else if (ce) begin
      if (startCmd) begin
        state_reg     <= ST_PUSH;
        axis_reg      <= 2'b00;
        wrIdx_reg     <= '0;
        remaining_reg <= count_reg;
      end else begin
        unique case (state_reg)
          ST_IDLE: begin
            axis_reg <= 2'b00;
          end
          ST_WAIT: begin
            if (sampleDue) begin
              state_reg <= ST_PUSH;
            end
          end
          ST_PUSH: begin
            if (pushed) begin
              axis_reg  <= axis_reg + 2'b01;
              wrIdx_reg <= wrIdx_reg + 1'b1;
              if (lastWord) begin
                remaining_reg <= remaining_reg - 16'h0001;
                state_reg     <= lastSample ? ST_IDLE : ST_WAIT;
              end
            end
          end
        endcase
      end
    end
  end

  // Every axis is caught on the same edge, so the four words of a sample share one instant.
  for (genvar a = 0; a < AXES; a++) begin : g_snap
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        snap_reg[a] <= 32'h00000000;
      end else if (ce && (startCmd || sampleDue)) begin
        snap_reg[a] <= snapCmd ? cmdPos[a] : fbPos[a];
      end
    end
  end

  // Busy follows the sequencer's next state, so the pin never lags the status bit.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      captureBusy <= 1'b0;
    end else if (ce) begin
      captureBusy <= startCmd || (state_reg != ST_IDLE && !lastSample);
    end
  end

  // Sample FIFO between sequencer and memory.
  logic               popValid;
  logic               popReady;
  logic [ENTRY_W-1:0] popData;
  logic               mrPend_reg;

  // A pending host read owns the memory for one cycle, so draining pauses meanwhile.
  assign popReady = !mrPend_reg;

  apsc_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .flush    (startCmd),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   ({wrIdx_reg, snap_reg[axis_reg]}),
    .outValid (popValid),
    .outReady (popReady),
    .outData  (popData)
  );

  // Sample memory, written from the FIFO and read on host request.
  logic [31:0]       mem [MEM_WORDS];
  logic [31:0]       memData_reg;
  logic [15:0]       mrAddr_reg;
  logic              mrWrite;
  logic [MEM_AW-1:0] mrIdx;

  // The memory word lands one cycle after its address is written; status bit 2 covers that gap.
  assign mrWrite = wrPend_reg && wrAddr_reg == MRADDR_OFS;
  assign mrIdx   = MEM_AW'(mrAddr_reg - MEM_BASE);

  // A restart discards whatever the FIFO still holds of the old run.
  always_ff @(posedge clk) begin
    if (ce && popValid && popReady && !startCmd) begin
      mem[popData[ENTRY_W-1:32]] <= popData[31:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mrAddr_reg  <= 16'h0000;
      mrPend_reg  <= 1'b0;
      memData_reg <= 32'h00000000;
    end else if (ce) begin
      if (mrWrite) begin
        mrAddr_reg <= hwdata[15:0];
        mrPend_reg <= 1'b1;
      end else if (mrPend_reg) begin
        mrPend_reg  <= 1'b0;
        memData_reg <= inRegion({16'h0000, mrAddr_reg}) ? mem[mrIdx] : 32'h00000000;
      end
    end
  end

  // Registered read data for the data phase.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
    end else if (ce && takeAddr) begin
      hrdata <= 32'h00000000;
      if (!hwrite && lowPage(haddr)) begin
        unique case (haddr[7:0])
          RESULT_OFS: hrdata <= {16'h0000, result_reg};
          MRADDR_OFS: hrdata <= {16'h0000, mrAddr_reg};
          MRDATA_OFS: hrdata <= memData_reg;
          STATUS_OFS: begin
            hrdata[STAT_BUSY]   <= state_reg != ST_IDLE;
            hrdata[STAT_SOURCE] <= source_reg;
            hrdata[STAT_MRBUSY] <= mrPend_reg || mrWrite;
          end
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== testbench/apsc_axis_model.sv
`timescale 1ns/10ps
`default_nettype none
module apsc_axis_model (
  input  wire logic [31:0]                      seed,
  output logic      [apsc_pkg::AXES-1:0][31:0] fbPos,
  output logic      [apsc_pkg::AXES-1:0][31:0] cmdPos
);
  import apsc_pkg::*;
  // Every axis and both sources differ, so a swapped axis or source shows up.
  always_comb begin
    for (int a = 0; a < AXES; a++) begin
      fbPos[a] = seed + 32'(a) * 32'h00000101;
      cmdPos[a] = ~fbPos[a];
    end
  end
endmodule
`default_nettype wire

// ===== testbench/apsc_capture_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module apsc_capture_monitor (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        captureBusy
);
  import apsc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence addr_ph(logic [7:0] ofs, logic wr);
    ce && hsel && htrans[1] && hready && hsize == 3'b010 && haddr == {24'h000000, ofs} && hwrite == wr;
  endsequence
  sequence start_cmd;
    addr_ph(CMD_OFS, 1'b1) ##1 ce && hwdata[19:16] == FUNC_START && hwdata[15:1] == 15'h0000;
  endsequence
  a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not OKAY");
  a_ready_no_wait: assert property ($past(rst_n) |-> hreadyout) else $error("wait state");
  a_start_sets_busy: assert property (start_cmd |=> captureBusy) else $error("start ignored");
  a_busy_has_cause: assert property ($rose(captureBusy) |-> $past(hwdata[19:16]) == FUNC_START)
    else $error("busy without start");
  a_status_shows_busy: assert property (addr_ph(STATUS_OFS, 1'b0) |=>
    hrdata[STAT_BUSY] == $past(captureBusy)) else $error("status busy wrong");
  a_rdata_holds: assert property (!(ce && hsel && htrans[1] && hready) |=> $stable(hrdata))
    else $error("hrdata moved");
  a_unmapped_zero: assert property (addr_ph(8'h14, 1'b0) |=> hrdata == 32'h0) else $error("unmapped");
  a_ce_freezes: assert property (!ce |=> $stable(captureBusy) && $stable(hrdata))
    else $error("ran with ce low");
endmodule
bind apsc_capture apsc_capture_monitor apsc_capture_monitor_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .captureBusy(captureBusy));
`default_nettype wire

// ===== testbench/apsc_capture_bench.sv
`timescale 1ns/10ps
`default_nettype none
module apsc_capture_bench;
  import apsc_pkg::*;
  logic                  clk, rst_n, ce, hsel, hwrite, hreadyout, hresp, captureBusy;
  logic [31:0]           haddr, hwdata, hrdata, seed, rnd, s1, rv;
  logic [1:0]            htrans;
  logic [2:0]            hsize;
  logic [AXES-1:0][31:0] fbPos, cmdPos;
  logic [19:0]           tw [8] = '{20'h40000, 20'h4FFFF, 20'hB0000, 20'hB1D4D, 20'hB1D4C, 20'hC0002,
                                    20'h10000, 20'hB0003};
  logic [15:0]           tr [8] = '{16'h1, 16'h0, 16'h1, 16'h1, 16'h0, 16'h1, 16'h2, 16'h0};
  int                    badCount = 0;
  int                    nCompared = 0;
  apsc_capture #(.TICK_CYCLES(4)) apsc_capture_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fbPos(fbPos), .cmdPos(cmdPos),
    .captureBusy(captureBusy));
  apsc_axis_model apsc_axis_model_inst (.seed(seed), .fbPos(fbPos), .cmdPos(cmdPos));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] expPos(input logic [31:0] s, input logic src, input int a);
    logic [31:0] p;
    p = s + 32'(a) * 32'h00000101;
    return src ? ~p : p;
  endfunction
  task automatic finalReport();
    if (badCount == 0 && nCompared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic waitRdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      chk("bus ready", 32'h1, 32'h0);
      finalReport();
    end
  endtask
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'b10;
    waitRdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    waitRdy();
    r = hrdata;
  endtask
  task automatic cmd(input logic [19:0] w, input logic [15:0] exp);
    ahb(CMD_OFS, 1'b1, {12'h000, w}, rv);
    ahb(RESULT_OFS, 1'b0, 32'h0, rv);
    chk("result code", {16'h0000, exp}, rv);
  endtask
  task automatic mem(input logic [15:0] a, input logic [31:0] exp);
    int n;
    ahb(MRADDR_OFS, 1'b1, {16'h0000, a}, rv);
    n = 0;
    do begin
      ahb(STATUS_OFS, 1'b0, 32'h0, rv);
      n++;
    end while (rv[STAT_MRBUSY] !== 1'b0 && n < 20);
    if (rv[STAT_MRBUSY] !== 1'b0) begin
      chk("memory read pending", 32'h0, {31'h0, rv[STAT_MRBUSY]});
      finalReport();
    end
    ahb(MRDATA_OFS, 1'b0, 32'h0, rv);
    chk("memory word", exp, rv);
  endtask
  task automatic waitDone();
    int n;
    n = 0;
    do begin
      ahb(CMD_OFS, 1'b1, {12'h000, FUNC_PROGRESS, 16'h0000}, rv);
      ahb(RESULT_OFS, 1'b0, 32'h0, rv);
      n++;
    end while (rv !== 32'h0 && n < 400);
    chk("progress", 32'h0, rv);
    if (rv !== 32'h0) finalReport();
  endtask
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    rnd = 32'h3FEBB1EA;
    seed = rnd;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    ahb(STATUS_OFS, 1'b0, 32'h0, rv);
    chk("status at reset", 32'h0, rv);
    chk("response", 32'h0, {31'h0, hresp});
    ahb(8'h14, 1'b0, 32'h0, rv);
    chk("unmapped read", 32'h0, rv);
    for (int i = 0; i < 8; i++) cmd(tw[i], tr[i]);
    rnd = lfsr(rnd);
    cmd({FUNC_INTERVAL, rnd[15:0] | 16'h0001}, RES_OK);
    cmd(20'h40005, RES_OK);
    hsize <= 3'b001;
    ahb(CMD_OFS, 1'b1, 32'h00010000, rv);
    hsize <= 3'b010;
    ahb(RESULT_OFS, 1'b0, 32'h0, rv);
    chk("narrow write ignored", 32'h0, rv);
    rnd = lfsr(rnd);
    s1 = rnd;
    seed <= s1;
    cmd(20'hC0001, RES_OK);
    ahb(STATUS_OFS, 1'b0, 32'h0, rv);
    chk("status running", 32'h3, rv & 32'h3);
    chk("busy pin", 32'h1, {31'h0, captureBusy});
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    mem(16'h4000, expPos(s1, 1'b1, 0));
    waitDone();
    for (int k = 0; k < 12; k++) mem(16'h4000 + 16'(k), expPos(s1, 1'b1, k % 4));
    mem(16'hB530, 32'h0);
    ahb(MRADDR_OFS, 1'b0, 32'h0, rv);
    chk("read address", 32'h0000B530, rv);
    ahb(STATUS_OFS, 1'b0, 32'h0, rv);
    chk("busy after done", 32'h0, rv & 32'h1);
    chk("busy pin idle", 32'h0, {31'h0, captureBusy});
    cmd(20'hB0002, RES_OK);
    cmd(20'hC0000, RES_OK);
    rnd = lfsr(rnd);
    seed <= rnd;
    repeat (2) @(posedge clk);
    cmd(20'hC0000, RES_OK);
    waitDone();
    for (int k = 0; k < 8; k++) mem(16'h4000 + 16'(k), expPos(rnd, 1'b0, k % 4));
    mem(16'h4008, expPos(s1, 1'b1, 0));
    finalReport();
  end
endmodule
`default_nettype wire
